/* design/uart_fifo_dma_ready_control.v */
// FIFO control, line state and DMA ready pins for one serial channel, AXI4-Lite register access
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "fifo_ctrl_map.vh"
module uart_fifo_dma_ready_control #(
	parameter AW = 5
) (
	input wire MCLK_I,
	input wire RESET_N_I,
	input wire [4:0] AWADDR_I,
	input wire AWVALID_I,
	output wire AWREADY_O,
	input wire [31:0] WDATA_I,
	input wire [3:0] WSTRB_I,
	input wire WVALID_I,
	output wire WREADY_O,
	output reg [1:0] BRESP_O,
	output reg BVALID_O,
	input wire BREADY_I,
	input wire [4:0] ARADDR_I,
	input wire ARVALID_I,
	output wire ARREADY_O,
	output reg [31:0] RDATA_O,
	output reg [1:0] RRESP_O,
	output reg RVALID_O,
	input wire RREADY_I,
	input wire RX_VALID_I,
	input wire [7:0] RX_DATA_I,
	input wire RX_PAR_ERR_I,
	input wire RX_FRM_ERR_I,
	input wire RX_BREAK_I,
	output wire RX_FULL_O,
	output wire TX_VALID_O,
	output wire [7:0] TX_DATA_O,
	input wire TX_TAKE_I,
	input wire TX_SHIFT_BUSY_I,
	output wire RX_IRQ_O,
	output wire TX_IRQ_O,
	output wire POLLED_O,
	output reg TX_DMA_REQUEST_N_O,
	output reg RX_DMA_REQUEST_N_O
);
	reg [7:0] fifo_setup_reg_ff;
	reg [7:0] irq_mask_reg_ff;
	reg [7:0] hold_rx_ff;
	reg hold_rx_full_ff;
	reg [7:0] hold_tx_ff;
	reg hold_tx_full_ff;
	reg overrun_ff;
	reg rx_armed_ff;
	reg aw_got_ff;
	reg w_got_ff;
	reg [4:0] aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	reg [31:0] nxt_rdata;
	reg nxt_rok;
	reg [5:0] rx_trig;
	reg [5:0] tx_trig;
	wire fifo_on;
	wire wr_fire;
	wire rd_fire;
	wire [4:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire rx_pop;
	wire tx_push;
	wire rx_push;
	wire [10:0] rx_word;
	wire [10:0] rx_head;
	wire [AW:0] rx_cnt;
	wire rx_full;
	wire rx_empty;
	wire [7:0] tx_head;
	wire [AW:0] tx_cnt;
	wire tx_full;
	wire tx_empty;
	wire rx_has;
	wire tx_none;
	wire [AW:0] err_cnt_in;
	reg [AW:0] err_cnt_ff;
	wire [7:0] line_state;
	wire rx_at_trig;
	wire tx_below;
	wire wr_lane;
	wire wr_at_hold;
	wire wr_at_mask;
	wire wr_at_setup;
	wire wr_known;
	wire rd_at_hold;
	wire rd_at_state;
	wire err_in;
	wire err_out;

	assign fifo_on = fifo_setup_reg_ff[`SETUP_EN];

	// Write address and data may arrive in either order
	assign AWREADY_O = !aw_got_ff && !BVALID_O;
	assign WREADY_O = !w_got_ff && !BVALID_O;
	assign wr_addr = aw_got_ff ? aw_addr_ff : AWADDR_I;
	assign wr_data = w_got_ff ? w_data_ff : WDATA_I;
	assign wr_strb = w_got_ff ? w_strb_ff : WSTRB_I;
	assign wr_fire = (aw_got_ff || (AWVALID_I && AWREADY_O)) && (w_got_ff || (WVALID_I && WREADY_O));

	// Byte lane 0 carries every writable register; other lanes are ignored
	assign wr_lane = wr_fire && wr_strb[0];
	assign wr_at_hold = ({wr_addr[4:2], 2'b00} == {1'b0, `OFS_TX_HOLD});
	assign wr_at_mask = ({wr_addr[4:2], 2'b00} == {1'b0, `OFS_IRQ_MASK});
	assign wr_at_setup = ({wr_addr[4:2], 2'b00} == {1'b0, `OFS_SETUP});
	// Line state and counts are read only, so writes there are refused
	assign wr_known = (wr_addr[4:2] <= 3'h2);

	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= 5'h00;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			BVALID_O <= 1'b0;
			BRESP_O <= `RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				BVALID_O <= 1'b1;
				BRESP_O <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (AWVALID_I && AWREADY_O) begin
					aw_got_ff <= 1'b1;
					aw_addr_ff <= AWADDR_I;
				end
				if (WVALID_I && WREADY_O) begin
					w_got_ff <= 1'b1;
					w_data_ff <= WDATA_I;
					w_strb_ff <= WSTRB_I;
				end
				if (BVALID_O && BREADY_I)
					BVALID_O <= 1'b0;
			end
		end
	end

	// Setup register: only a write with enable set programs the other fields
	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			fifo_setup_reg_ff <= `SETUP_RST;
			irq_mask_reg_ff <= `MASK_RST;
		end else if (wr_lane) begin
			if (wr_at_setup) begin
				if (wr_data[`SETUP_EN])
					fifo_setup_reg_ff <= {wr_data[7:3], 2'b00, 1'b1};
				else
					fifo_setup_reg_ff <= `SETUP_RST;
			end
			if (wr_at_mask)
				irq_mask_reg_ff <= wr_data[7:0];
		end
	end

	// Clear pulses self-clear: they are never stored
	wire setup_wr = wr_lane && wr_at_setup;
	wire clr_rx = setup_wr && (wr_data[`SETUP_RXCLR] || (wr_data[`SETUP_EN] != fifo_on)) && wr_data[`SETUP_EN]
		|| setup_wr && !wr_data[`SETUP_EN] && fifo_on;
	wire clr_tx = setup_wr && (wr_data[`SETUP_TXCLR] || (wr_data[`SETUP_EN] != fifo_on)) && wr_data[`SETUP_EN]
		|| setup_wr && !wr_data[`SETUP_EN] && fifo_on;
	assign tx_push = wr_lane && wr_at_hold;

	// Read channel, one cycle latency
	assign ARREADY_O = !RVALID_O;
	assign rd_fire = ARVALID_I && ARREADY_O;
	assign rd_at_hold = ({ARADDR_I[4:2], 2'b00} == {1'b0, `OFS_RX_HOLD});
	assign rd_at_state = ({ARADDR_I[4:2], 2'b00} == {1'b0, `OFS_LINE_STATE});
	assign rx_pop = rd_fire && rd_at_hold;

	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_rok = 1'b1;
		case ({ARADDR_I[4:2], 2'b00})
			{1'b0, `OFS_RX_HOLD}: nxt_rdata = {24'h000000, fifo_on ? rx_head[7:0] : hold_rx_ff};
			{1'b0, `OFS_IRQ_MASK}: nxt_rdata = {24'h000000, irq_mask_reg_ff};
			{1'b0, `OFS_SETUP_RB}: nxt_rdata = {24'h000000, fifo_setup_reg_ff};
			{1'b0, `OFS_LINE_STATE}: nxt_rdata = {24'h000000, line_state};
			`OFS_CNT: nxt_rdata = {16'h0000, {(8-AW-1){1'b0}}, tx_cnt, {(8-AW-1){1'b0}}, rx_cnt};
			default: nxt_rok = 1'b0;
		endcase
	end

	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h00000000;
			RRESP_O <= `RESP_OKAY;
		end else if (rd_fire) begin
			RVALID_O <= 1'b1;
			RDATA_O <= nxt_rdata;
			RRESP_O <= nxt_rok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end

	// Receive path keeps storing past the trigger, drops only when full
	assign rx_push = RX_VALID_I && fifo_on;
	assign rx_word = {RX_BREAK_I, RX_FRM_ERR_I, RX_PAR_ERR_I, RX_DATA_I};
	assign RX_FULL_O = fifo_on ? rx_full : hold_rx_full_ff;

	char_fifo #(.W(11), .AW(AW)) u_rx_fifo (
		.clk_i(MCLK_I),
		.rst_n_i(RESET_N_I),
		.clr_i(clr_rx),
		.wr_i(rx_push),
		.wdata_i(rx_word),
		.rd_i(rx_pop && fifo_on),
		.rdata_o(rx_head),
		.count_o(rx_cnt),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	char_fifo #(.W(8), .AW(AW)) u_tx_fifo (
		.clk_i(MCLK_I),
		.rst_n_i(RESET_N_I),
		.clr_i(clr_tx),
		.wr_i(tx_push && fifo_on),
		.wdata_i(wr_data[7:0]),
		.rd_i(TX_TAKE_I && fifo_on),
		.rdata_o(tx_head),
		.count_o(tx_cnt),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	assign TX_VALID_O = fifo_on ? !tx_empty : hold_tx_full_ff;
	assign TX_DATA_O = fifo_on ? tx_head : hold_tx_ff;

	// Single holding registers when FIFOs are off; overrun is sticky until line state read
	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hold_rx_ff <= 8'h00;
			hold_rx_full_ff <= 1'b0;
			hold_tx_ff <= 8'h00;
			hold_tx_full_ff <= 1'b0;
			overrun_ff <= 1'b0;
		end else begin
			if (!fifo_on && RX_VALID_I) begin
				hold_rx_ff <= RX_DATA_I;
				hold_rx_full_ff <= 1'b1;
			end else if (rx_pop || fifo_on) begin
				hold_rx_full_ff <= 1'b0;
			end
			if (!fifo_on && tx_push) begin
				hold_tx_ff <= wr_data[7:0];
				hold_tx_full_ff <= 1'b1;
			end else if (TX_TAKE_I || fifo_on) begin
				hold_tx_full_ff <= 1'b0;
			end
			// Set wins over the read clear
			if (RX_VALID_I && (fifo_on ? rx_full : (hold_rx_full_ff && !rx_pop)))
				overrun_ff <= 1'b1;
			else if (rd_fire && rd_at_state)
				overrun_ff <= 1'b0;
		end
	end

	// Count of stored characters carrying an error
	assign err_cnt_in = {(AW+1){1'b0}};
	assign err_in = rx_push && !rx_full && |rx_word[10:8];
	assign err_out = rx_pop && fifo_on && !rx_empty && |rx_head[10:8];
	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			err_cnt_ff <= {(AW+1){1'b0}};
		else if (clr_rx)
			err_cnt_ff <= err_cnt_in;
		else if (err_in && !err_out)
			err_cnt_ff <= err_cnt_ff + 1'b1;
		else if (err_out && !err_in)
			err_cnt_ff <= err_cnt_ff - 1'b1;
	end

	assign rx_has = fifo_on ? !rx_empty : hold_rx_full_ff;
	assign tx_none = fifo_on ? tx_empty : !hold_tx_full_ff;
	assign line_state = {
		fifo_on && (err_cnt_ff != {(AW+1){1'b0}}),
		tx_none && !TX_SHIFT_BUSY_I,
		tx_none,
		fifo_on && !rx_empty && rx_head[10],
		fifo_on && !rx_empty && rx_head[9],
		fifo_on && !rx_empty && rx_head[8],
		overrun_ff,
		rx_has
	};

	// Trigger level decode
	always @* begin
		case (fifo_setup_reg_ff[`SETUP_RXTRG_LO+1:`SETUP_RXTRG_LO])
			2'b00: rx_trig = `RXTRG_0;
			2'b01: rx_trig = `RXTRG_1;
			2'b10: rx_trig = `RXTRG_2;
			2'b11: rx_trig = `RXTRG_3;
			default: rx_trig = `RXTRG_0;
		endcase
		case (fifo_setup_reg_ff[`SETUP_TXTRG_LO+1:`SETUP_TXTRG_LO])
			2'b00: tx_trig = `TXTRG_0;
			2'b01: tx_trig = `TXTRG_1;
			2'b10: tx_trig = `TXTRG_2;
			2'b11: tx_trig = `TXTRG_3;
			default: tx_trig = `TXTRG_0;
		endcase
	end

	assign rx_at_trig = ({{(6-AW-1){1'b0}}, rx_cnt} >= rx_trig);
	// Equal to the level is not below: the request waits for one more take
	assign tx_below = ({{(6-AW-1){1'b0}}, tx_cnt} < tx_trig);

	// Interrupt levels; FIFOs on with mask bits 3:0 clear means polled, nothing raised
	assign RX_IRQ_O = irq_mask_reg_ff[0] && (fifo_on ? rx_at_trig : hold_rx_full_ff);
	assign TX_IRQ_O = irq_mask_reg_ff[1] && (fifo_on ? tx_below : !hold_tx_full_ff);
	assign POLLED_O = fifo_on && (irq_mask_reg_ff[3:0] == 4'h0);

	// Mode 1 receive request latches at trigger, held until FIFO drains
	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			rx_armed_ff <= 1'b0;
		else if (!fifo_on || rx_empty)
			rx_armed_ff <= 1'b0;
		else if (rx_at_trig)
			rx_armed_ff <= 1'b1;
	end

	// Ready pins registered, active low
	always @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			TX_DMA_REQUEST_N_O <= 1'b0;
			RX_DMA_REQUEST_N_O <= 1'b1;
		end else if (fifo_on && fifo_setup_reg_ff[`SETUP_DMA]) begin
			// Between trigger and full the transmit pin keeps its last level
			if (tx_full)
				TX_DMA_REQUEST_N_O <= 1'b1;
			else if (tx_below)
				TX_DMA_REQUEST_N_O <= 1'b0;
			// Released as soon as the store runs dry, not a cycle later
			RX_DMA_REQUEST_N_O <= !((rx_armed_ff && !rx_empty) || rx_at_trig);
		end else begin
			// Mode 0: transmit ready low while empty, receive ready low while any character held
			TX_DMA_REQUEST_N_O <= !tx_none;
			RX_DMA_REQUEST_N_O <= !rx_has;
		end
	end
endmodule

/* design/fifo_ctrl_map.vh */
// Register offsets, field positions, reset values and trigger levels for the FIFO/DMA ready control block
// Operation
// - FIFOs on and mask bits 3:0 clear gives polled mode, no interrupts.
// - Receive and transmit status sit in separate line state bits.
// - Line state bit 0 is one while receive FIFO holds a byte.
// - Line state bits 4:1 report overrun, parity, framing, break.
// - Line state bit 5 is one when transmit FIFO is empty.
// - Line state bit 6 needs transmit FIFO and shift register empty.
// - Line state bit 7 flags any error among stored receive characters.
// - Receive trigger field bits 7:6 select receive interrupt level.
// - Receive continues storing past trigger until FIFO full.
// - Transmit trigger bits 5:4 reset to zero (16); interrupt below level.
// - Setup bit 3 selects DMA mode, zero is mode 0.
// - Mode 0 transmit ready low when empty, high after first write.
// - Mode 0 receive ready low while any character held.
// - Mode 1 transmit request set while count below transmit trigger.
// - Mode 1 receive request set at trigger, held until receive FIFO empty.
// - Receive codes 00..11 select levels 8, 16, 24, 28.
// - Transmit codes 00..11 select levels 16, 8, 24, 30.
// - Other setup bits take effect only when enable written one together.
// - Mode 1 transmit ready high when full, low once count drops below trigger.
`ifndef FIFO_CTRL_MAP_VH
`define FIFO_CTRL_MAP_VH
`define OFS_RX_HOLD 4'h0
`define OFS_TX_HOLD 4'h0
`define OFS_SETUP 4'h8
`define OFS_IRQ_MASK 4'h4
`define OFS_LINE_STATE 4'hC
`define OFS_SETUP_RB 4'h8
`define OFS_CNT 5'h10
`define SETUP_EN 0
`define SETUP_RXCLR 1
`define SETUP_TXCLR 2
`define SETUP_DMA 3
`define SETUP_TXTRG_LO 4
`define SETUP_RXTRG_LO 6
`define SETUP_RST 8'h00
`define MASK_RST 8'h00
`define RXTRG_0 6'h08
`define RXTRG_1 6'h10
`define RXTRG_2 6'h18
`define RXTRG_3 6'h1C
`define TXTRG_0 6'h10
`define TXTRG_1 6'h08
`define TXTRG_2 6'h18
`define TXTRG_3 6'h1E
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* design/char_fifo.v */
// Synchronous character FIFO with level count and clear
module char_fifo #(
	parameter W = 8,
	parameter AW = 5
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire clr_i,
	input wire wr_i,
	input wire [W-1:0] wdata_i,
	input wire rd_i,
	output wire [W-1:0] rdata_o,
	output wire [AW:0] count_o,
	output wire full_o,
	output wire empty_o
);
	reg [W-1:0] mem [0:(1<<AW)-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0] cnt_ff;
	wire do_wr;
	wire do_rd;
	assign full_o = cnt_ff[AW];
	assign empty_o = (cnt_ff == {(AW+1){1'b0}});
	assign do_wr = wr_i && !full_o;
	assign do_rd = rd_i && !empty_o;
	assign rdata_o = mem[rp_ff];
	assign count_o = cnt_ff;
	always @(posedge clk_i) begin
		if (do_wr)
			mem[wp_ff] <= wdata_i;
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else if (clr_i) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wp_ff <= wp_ff + 1'b1;
			if (do_rd)
				rp_ff <= rp_ff + 1'b1;
			if (do_wr && !do_rd)
				cnt_ff <= cnt_ff + 1'b1;
			else if (do_rd && !do_wr)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule

/* bench/fifo_ready_checker_assertions.sv */
// Bus handshake and ready pin checks for the FIFO/DMA ready control block
module fifo_ready_checker #(
	parameter AW = 5
) (
	input wire MCLK_I,
	input wire RESET_N_I,
	input wire AWVALID_I,
	input wire AWREADY_O,
	input wire WVALID_I,
	input wire WREADY_O,
	input wire [1:0] BRESP_O,
	input wire BVALID_O,
	input wire BREADY_I,
	input wire ARVALID_I,
	input wire ARREADY_O,
	input wire [31:0] RDATA_O,
	input wire RVALID_O,
	input wire RREADY_I,
	input wire TX_VALID_O,
	input wire RX_IRQ_O,
	input wire TX_IRQ_O,
	input wire POLLED_O,
	input wire TX_DMA_REQUEST_N_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	sequence wr_taken;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence b_waiting;
		BVALID_O && !BREADY_I;
	endsequence
	a_write_answer: assert property (wr_taken |=> BVALID_O) else $error("write not answered");
	a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O) else $error("read not answered");
	a_bresp_hold: assert property (b_waiting |=> BVALID_O && $stable(BRESP_O)) else $error("write answer dropped");
	a_rdata_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read answer dropped");
	a_read_busy: assert property (RVALID_O |-> !ARREADY_O) else $error("address taken while answering");
	a_write_busy: assert property (BVALID_O |-> !AWREADY_O) else $error("write taken while answering");
	a_polled_quiet: assert property (POLLED_O |-> !RX_IRQ_O && !TX_IRQ_O) else $error("irq in polled mode");
	a_tx_empty_req: assert property (!TX_VALID_O |=> !TX_DMA_REQUEST_N_O) else $error("no tx request");
endmodule
bind uart_fifo_dma_ready_control fifo_ready_checker #(.AW(AW)) u_chk (
	.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
	.WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
	.ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
	.RREADY_I(RREADY_I), .TX_VALID_O(TX_VALID_O), .RX_IRQ_O(RX_IRQ_O), .TX_IRQ_O(TX_IRQ_O),
	.POLLED_O(POLLED_O), .TX_DMA_REQUEST_N_O(TX_DMA_REQUEST_N_O));

/* bench/serial_side_model.sv */
// Serial side stand-in: delivers received characters, takes transmit characters
module serial_side_model (
	input wire logic clk_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic [2:0] rx_err_o,
	output logic tx_take_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		rx_err_o = 3'h0;
		tx_take_o = 1'b0;
	end
	// Data inverted between pulses so a stale byte never looks valid
	task automatic send(input logic [7:0] d, input logic [2:0] e);
		rx_valid_o <= 1'b1;
		rx_data_o <= d;
		rx_err_o <= e;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~d;
		rx_err_o <= ~e;
		@(posedge clk_i);
		#1;
	endtask
	task automatic take;
		tx_take_o <= 1'b1;
		@(posedge clk_i);
		tx_take_o <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
endmodule

/* bench/uart_fifo_dma_ready_control_tb.sv */
// Self-checking bench for the FIFO/DMA ready control block
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
$display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module uart_fifo_dma_ready_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK_I = 1'b0, RESET_N_I = 1'b0, AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
	logic ARVALID_I = 1'b0, RREADY_I = 1'b0, TX_SHIFT_BUSY_I = 1'b0, RX_VALID_I, TX_TAKE_I;
	logic RX_PAR_ERR_I, RX_FRM_ERR_I, RX_BREAK_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	logic RX_FULL_O, TX_VALID_O, RX_IRQ_O, TX_IRQ_O, POLLED_O, TX_DMA_REQUEST_N_O, RX_DMA_REQUEST_N_O;
	logic [4:0] AWADDR_I = 5'h00, ARADDR_I = 5'h00;
	logic [31:0] WDATA_I = 32'h0, RDATA_O;
	logic [3:0] WSTRB_I = 4'hF;
	logic [7:0] RX_DATA_I, TX_DATA_O;
	logic [1:0] BRESP_O, RRESP_O;
	int mismatches = 0, samples_checked = 0;
	uart_fifo_dma_ready_control #(.AW(5)) u_uart_fifo_dma_ready_control (.*);
	serial_side_model u_side (.clk_i(MCLK_I), .rx_valid_o(RX_VALID_I), .rx_data_o(RX_DATA_I),
		.rx_err_o({RX_BREAK_I, RX_FRM_ERR_I, RX_PAR_ERR_I}), .tx_take_o(TX_TAKE_I));
	always #2.5 MCLK_I = ~MCLK_I;
	task automatic wt(input int n);
		repeat (n) @(posedge MCLK_I);
		#1;
	endtask
	// Ready held back one cycle so the answer must stand
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		AWADDR_I <= a;
		WDATA_I <= {24'h0, d};
		AWVALID_I <= 1'b1;
		WVALID_I <= 1'b1;
		do begin
			@(posedge MCLK_I);
			if (AWREADY_O) AWVALID_I <= 1'b0;
			if (WREADY_O) WVALID_I <= 1'b0;
		end while (!BVALID_O);
		BREADY_I <= 1'b1;
		@(posedge MCLK_I);
		BREADY_I <= 1'b0;
		`CHK(BRESP_O, r)
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		do begin
			@(posedge MCLK_I);
			if (ARREADY_O) ARVALID_I <= 1'b0;
		end while (!RVALID_O);
		RREADY_I <= 1'b1;
		@(posedge MCLK_I);
		RREADY_I <= 1'b0;
		d = RDATA_O;
		r = RRESP_O;
		#1;
	endtask
	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, 2'h0)
	endtask
	task automatic t_reset;
		`CHK(TX_DMA_REQUEST_N_O, 1'b0)
		`CHK(RX_DMA_REQUEST_N_O, 1'b1)
		rc(5'h08, 32'h0);
		rc(5'h0C, 32'h60);
	endtask
	task automatic t_mode0;
		wr(5'h00, 8'hA5, 2'h0);
		wt(2);
		`CHK(TX_DMA_REQUEST_N_O, 1'b1)
		`CHK(TX_DATA_O, 8'hA5)
		rc(5'h0C, 32'h0);
		u_side.take;
		wt(2);
		`CHK(TX_DMA_REQUEST_N_O, 1'b0)
		TX_SHIFT_BUSY_I <= 1'b1;
		rc(5'h0C, 32'h20);
		TX_SHIFT_BUSY_I <= 1'b0;
		wr(5'h08, 8'h01, 2'h0);
		wr(5'h04, 8'h00, 2'h0);
		wt(1);
		`CHK(POLLED_O, 1'b1)
		for (int i = 0; i < 3; i++) begin
			u_side.send(8'h40 + i[7:0], 3'h1 << i);
			wt(1);
			`CHK(RX_DMA_REQUEST_N_O, 1'b0)
			rc(5'h0C, 32'hE1 | (32'h4 << i));
			rc(5'h00, 32'h40 + i);
			wt(2);
			`CHK(RX_DMA_REQUEST_N_O, 1'b1)
		end
	endtask
	task automatic t_rx1;
		int lvl[4] = '{8, 16, 24, 28};
		logic [31:0] d;
		logic [1:0] r;
		wr(5'h04, 8'h01, 2'h0);
		for (int c = 0; c < 4; c++) begin
			wr(5'h08, {c[1:0], 6'h0F}, 2'h0);
			for (int i = 1; i < lvl[c]; i++) u_side.send(i[7:0], 3'h0);
			wt(2);
			`CHK(RX_DMA_REQUEST_N_O, 1'b1)
			`CHK(RX_IRQ_O, 1'b0)
			u_side.send(8'hC0, 3'h0);
			wt(2);
			`CHK(RX_DMA_REQUEST_N_O, 1'b0)
			`CHK(RX_IRQ_O, 1'b1)
			for (int i = lvl[c]; i < 33; i++) u_side.send(8'hC1, 3'h0);
			`CHK(RX_FULL_O, 1'b1)
			rc(5'h10, 32'd32);
			rc(5'h0C, 32'h63);
			for (int i = 0; i < 31; i++) rd(5'h00, d, r);
			wt(2);
			`CHK(RX_DMA_REQUEST_N_O, 1'b0)
			rd(5'h00, d, r);
			wt(2);
			`CHK(RX_DMA_REQUEST_N_O, 1'b1)
		end
	endtask
	task automatic t_tx1;
		int lvl[4] = '{16, 8, 24, 30};
		wr(5'h04, 8'h02, 2'h0);
		for (int c = 0; c < 4; c++) begin
			wr(5'h08, {2'h0, c[1:0], 4'hF}, 2'h0);
			for (int i = 0; i < 32; i++) wr(5'h00, i[7:0], 2'h0);
			wt(2);
			`CHK(TX_DMA_REQUEST_N_O, 1'b1)
			for (int i = 32; i > lvl[c]; i--) u_side.take;
			wt(2);
			`CHK(TX_DMA_REQUEST_N_O, 1'b1)
			`CHK(TX_IRQ_O, 1'b0)
			rc(5'h10, lvl[c] << 8);
			u_side.take;
			wt(2);
			`CHK(TX_DMA_REQUEST_N_O, 1'b0)
			`CHK(TX_IRQ_O, 1'b1)
		end
	endtask
	task automatic t_setup;
		logic [31:0] d;
		logic [1:0] r;
		wr(5'h08, 8'hFF, 2'h0);
		rc(5'h08, 32'hF9);
		wr(5'h08, 8'hF8, 2'h0);
		rc(5'h08, 32'h0);
		wr(5'h14, 8'h00, 2'h2);
		rd(5'h18, d, r);
		`CHK(r, 2'h2)
		`CHK(d, 32'h0)
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge MCLK_I);
		RESET_N_I <= 1'b1;
		wt(1);
		t_reset;
		t_mode0;
		t_rx1;
		t_tx1;
		t_setup;
		give_verdict;
	end
	initial begin
		repeat (60000) @(posedge MCLK_I);
		mismatches++;
		give_verdict;
	end
endmodule
